// ===== shared/logger_pkg.sv
// Function
// - Record while run flag on; never self-clear
// - Read-only 32-bit record count, plus one
// - Limit flag at quantity or cyclic mode
// - Store starts on request rise with code
// - Only code 5AA5 stores; others ignored
// - Card-present flag follows card insertion
// - Busy flag on throughout card write
// - Error flag on when card operation fails
// - Last error code kept, read-only
// - Flag shows valid parameters are loaded
// - At quantity stop or overwrite oldest
// - Auto store when limit reached
// - Read-only items ignore program writes
`default_nettype none
package logger_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_STATUS   = 8'h00;
    localparam logic [7:0] OFF_CONTROL  = 8'h04;
    localparam logic [7:0] OFF_CODE     = 8'h08;
    localparam logic [7:0] OFF_COUNT    = 8'h0C;
    localparam logic [7:0] OFF_ERRCODE  = 8'h10;
    localparam logic [7:0] OFF_QUANTITY = 8'h14;
    localparam logic [7:0] OFF_CONFIG   = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h20;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h24;
    // Status register bit positions.
    localparam int ST_PRESENT = 0;
    localparam int ST_BUSY    = 1;
    localparam int ST_ERROR   = 2;
    localparam int ST_LIMIT   = 3;
    localparam int ST_VALID   = 4;
    // Control register bit positions.
    localparam int CT_RUN     = 0;
    localparam int CT_REQUEST = 1;
    // Config register bit positions.
    localparam int CF_OVERWRITE = 0;
    localparam int CF_AUTOSTORE = 1;
    // Interrupt bit positions.
    localparam int IRQ_LIMIT = 0;
    localparam int IRQ_DONE  = 1;
    localparam int IRQ_ERROR = 2;
    localparam int IRQ_W     = 3;
    // The only accepted store control code.
    localparam logic [15:0] STORE_CODE     = 16'h5AA5;
    // Reset values.
    localparam logic [31:0] QUANTITY_RST   = 32'h0000_03E8;
    localparam logic [15:0] ERR_NONE       = 16'h0000;
    // Card store states.
    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_WAIT} store_state_e;
    // Card side signals travelling together.
    typedef struct packed {
        logic        present;
        logic        done;
        logic        fail;
        logic [15:0] err_code;
    } card_resp_s;
endpackage
`default_nettype wire

// ===== verilog/data_logger_store_control.sv
// The APB interface to the registers and the register offsets were decided locally.
`default_nettype none
module data_logger_store_control
    import logger_pkg::*;
#(
    parameter int DEPTH_W = 14
) (
    // Clock and reset.
    input  wire logic               CLK,
    input  wire logic               SYS_RST,
    // APB slave.
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [7:0]         PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    // Sample stream from the scan.
    input  wire logic               SAMPLE_VALID,
    input  wire logic [31:0]        SAMPLE_DATA,
    // Parameter download status.
    input  wire logic               PARAMS_LOADED,
    // Memory card side.
    input  wire logic               CARD_PRESENT,
    input  wire logic               CARD_DONE,
    input  wire logic               CARD_FAIL,
    input  wire logic [15:0]        CARD_ERR_CODE,
    output logic                    CARD_START,
    output logic      [DEPTH_W-1:0] CARD_LENGTH,
    // Interrupt.
    output logic                    IRQ
);
    // Samples arrive as one-cycle pulses from the scan and are
    // written into a local memory while the run flag is on and a
    // valid parameter set is present.
    // Each record adds one to a 32-bit count.
    // When the count meets the quantity the block either holds
    // (stop mode) or wraps its pointer and carries on over the
    // oldest entries (overwrite mode).
    // A store is started by a rising request flag, or by the
    // rising limit flag when auto-store is on.
    // Both triggers need the store code in place.
    // The card answers a start pulse with a done or fail level.

    // Card pins and the parameter flag come from outside the
    // clock domain, so each passes two flip-flops first.
    // The card response travels as one struct, so that all of
    // its fields are captured on the same edge.
    // Two-stage synchronisers for the card pins.
    card_resp_s   card_s1_r;                  // First stage, read only by the second.
    card_resp_s   card_s2_r;                  // Synchronised card response.

    // Program-visible flags and registers.
    logic         run_r;                      // Recording-run flag.
    logic         req_r;                      // Store-request flag.
    logic         req_prev_r;                 // Request flag one cycle ago.
    logic [15:0]  code_r;                     // Store control code.
    logic [31:0]  count_r;                    // Recorded entry count.
    logic [31:0]  quantity_r;                 // Configured sample quantity.
    logic [1:0]   config_r;                   // Full action and auto-store.
    logic         limit_r;                    // Limit-reached flag.
    logic         limit_prev_r;               // Limit flag one cycle ago.
    logic         cyclic_r;                   // Overwrite has wrapped once.
    logic         error_r;                    // Card error flag.
    logic [15:0]  errcode_r;                  // Last card error code.

    // Interrupt state, recording memory and store sequencing.
    // The memory is sized by the depth parameter.
    logic [IRQ_W-1:0] irq_stat_r;             // Sticky interrupt status.
    logic [IRQ_W-1:0] irq_en_r;               // Interrupt enables.
    logic [DEPTH_W-1:0] wr_ptr_r;             // Next buffer write slot.
    logic [31:0]  buffer_r [0:(1<<DEPTH_W)-1];// Recorded sample memory.
    store_state_e state_r;                    // Card store state.
    logic         valid_s1_r;                 // Parameter flag first stage.
    logic         valid_r;                    // Synchronised parameter flag.

    // Decoded strobes shared between the processes.
    logic         bus_wr;                     // A write completes this cycle.
    logic         take;                       // A sample is recorded.
    logic         at_quantity;                // Count has met the quantity.
    logic         store_go;                   // A store should begin.

    // Bus write strobe; the slave answers without wait states.
    // Every register is a plain flip-flop word, so nothing has
    // to stall the bus.
    // PREADY is tied high and no transfer is refused with an error.
    // A write lands on the edge that samples the access phase.
    assign bus_wr  = PSEL && PENABLE && PWRITE;
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;

    // Synchronise card and parameter inputs, which come from outside.
    // Only the second stage is read by the rest of the block.
    // The first stage may go metastable and must stay private.
    // This costs two cycles of latency on every card event.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            card_s1_r  <= '0;
            card_s2_r  <= '0;
            valid_s1_r <= 1'b0;
            valid_r    <= 1'b0;
        end else begin
            card_s1_r  <= '{CARD_PRESENT, CARD_DONE, CARD_FAIL, CARD_ERR_CODE};
            card_s2_r  <= card_s1_r;
            valid_s1_r <= PARAMS_LOADED;
            valid_r    <= valid_s1_r;
        end
    end

    // Full condition and when a sample is taken.
    // The compare is greater-or-equal, so that a quantity lowered
    // below the current count still reads as full.
    assign at_quantity = (count_r >= quantity_r);
    // Stop mode holds at the quantity; overwrite mode keeps going.
    // Without a valid parameter set the run flag still sets but no sample is taken,
    // so neither the memory nor the count can move.
    // A sample pulse outside these conditions is simply lost.
    assign take = SAMPLE_VALID && run_r && valid_r &&
                  (config_r[CF_OVERWRITE] || !at_quantity);

    // Run and request flags change only by program writes.
    // Nothing in the block clears the run flag, not even a full
    // memory; the program has to write it low itself.
    // The request flag is not cleared either, so a second store
    // needs a write of zero and then of one again.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            run_r <= 1'b0;
            req_r <= 1'b0;
        end else if (bus_wr && PADDR == OFF_CONTROL) begin
            // Both flags are written together from one word.
            run_r <= PWDATA[CT_RUN];
            req_r <= PWDATA[CT_REQUEST];
        end
    end

    // Writable configuration registers; read-only items have no write path.
    // Each register decodes its own offset, so a write to an
    // unmapped or read-only offset changes nothing.
    // The store code is kept whole; only the exact code is accepted.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            code_r     <= 16'h0000;
            quantity_r <= QUANTITY_RST;
            config_r   <= 2'b00;
            irq_en_r   <= '0;
        end else if (bus_wr) begin
            if (PADDR == OFF_CODE) begin
                code_r <= PWDATA[15:0];
            end
            // A quantity of zero makes the memory read as full at once.
            if (PADDR == OFF_QUANTITY) begin
                quantity_r <= PWDATA;
            end
            if (PADDR == OFF_CONFIG) begin
                config_r <= PWDATA[1:0];
            end
            if (PADDR == OFF_IRQ_EN) begin
                irq_en_r <= PWDATA[IRQ_W-1:0];
            end
        end
    end

    // Record samples into the buffer, wrapping in overwrite mode.
    // The memory has no reset: only the entries below the write
    // pointer, which is reset, carry meaning, or those below the quantity once overwrite has wrapped.
    // Leaving it unreset lets it map onto a plain memory macro.
    always_ff @(posedge CLK) begin
        if (take) begin
            buffer_r[wr_ptr_r] <= SAMPLE_DATA;
        end
    end

    // Count records and move the write pointer.
    // The count never wraps back with the pointer; it keeps
    // growing so the program sees the full number of records.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            count_r  <= 32'h0000_0000;
            wr_ptr_r <= '0;
            cyclic_r <= 1'b0;
        end else if (take) begin
            count_r <= count_r + 32'h0000_0001;
            // Only overwrite mode wraps; in stop mode the pointer
            // stays as the length of what was recorded.
            if (config_r[CF_OVERWRITE] &&
                (32'(wr_ptr_r) + 32'h0000_0001 >= quantity_r)) begin
                wr_ptr_r <= '0;
                cyclic_r <= 1'b1;
            end else begin
                wr_ptr_r <= wr_ptr_r + DEPTH_W'(1);
            end
        end
    end

    // Limit flag follows the count or cyclic recording.
    // The previous values feed the edge detectors below.
    // They reset low, the idle level of both flags, so no false
    // edge follows reset.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            limit_r      <= 1'b0;
            limit_prev_r <= 1'b0;
            req_prev_r   <= 1'b0;
        end else begin
            limit_r      <= at_quantity || cyclic_r;
            limit_prev_r <= limit_r;
            req_prev_r   <= req_r;
        end
    end

    // Manual store on a rising request with the code, or automatic store.
    // Any code other than the store code blocks both triggers.
    // A trigger that finds the block busy or no card is dropped.
    // The trigger is a single-cycle term and is not remembered.
    assign store_go = (code_r == STORE_CODE) &&
                      ((req_r && !req_prev_r) ||
                       (config_r[CF_AUTOSTORE] && limit_r && !limit_prev_r));

    // Card store sequencing; busy covers the whole write.
    // The start pulse lasts one cycle, and the length handed
    // over is the write pointer at that moment.
    // The card answer arrives two cycles late through the
    // synchroniser, but a done or fail that stands one cycle is enough.
    // Removing the card also ends a store; only a card that stays in and never answers holds busy.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_r     <= ST_IDLE;
            CARD_START  <= 1'b0;
            CARD_LENGTH <= '0;
        end else begin
            CARD_START <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    // Start only with a card in; a refused trigger is lost.
                    if (store_go && card_s2_r.present) begin
                        state_r     <= ST_WRITE;
                        CARD_START  <= 1'b1;
                        CARD_LENGTH <= wr_ptr_r;
                    end
                end
                ST_WRITE: begin
                    // One cycle for the card to see the start pulse.
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    // A pulled card also ends the store.
                    if (card_s2_r.done || card_s2_r.fail || !card_s2_r.present) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    // The unused fourth code returns to idle.
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Error flag and code; a new store that starts clears the flag.
    // The code crosses as a 16-bit word, so it is taken again on
    // every cycle that the synchronised fail level still stands.
    // The last copy then comes from a capture made after the word
    // had settled at the pin.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            error_r   <= 1'b0;
            errcode_r <= ERR_NONE;
        end else if (state_r == ST_WAIT && card_s2_r.fail) begin
            error_r   <= 1'b1;
            errcode_r <= card_s2_r.err_code;
        end else if (state_r == ST_IDLE && store_go && card_s2_r.present) begin
            error_r <= 1'b0;
        end else if (error_r && card_s2_r.fail) begin
            errcode_r <= card_s2_r.err_code;
        end
    end

    // Sticky interrupt status; set wins over clear.
    // A clear written on the edge of a new event only clears the
    // bits that did not fire on that edge.
    // The clear register itself holds nothing and reads as zero.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r &
                           ~((bus_wr && PADDR == OFF_IRQ_CLR) ? PWDATA[IRQ_W-1:0] : '0)) |
                          {card_s2_r.fail && state_r == ST_WAIT,
                           card_s2_r.done && state_r == ST_WAIT,
                           limit_r && !limit_prev_r};
        end
    end

    // Interrupt output, high while an enabled status bit is set.
    // It is registered so the pin cannot glitch.
    // It lags the status and enable registers by one cycle.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_r & irq_en_r);
        end
    end

    // Read data mux, registered in the setup cycle.
    // Loading in the setup cycle gives a full cycle before the
    // access edge and keeps the data steady until the next read.
    // Status is sampled at that point, one cycle before the
    // master takes it.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= 32'h0000_0000;
            unique case (PADDR)
                // Status bits are live copies of the internal flags.
                OFF_STATUS: begin
                    PRDATA[ST_PRESENT] <= card_s2_r.present;
                    PRDATA[ST_BUSY]    <= (state_r != ST_IDLE);
                    PRDATA[ST_ERROR]   <= error_r;
                    PRDATA[ST_LIMIT]   <= limit_r;
                    PRDATA[ST_VALID]   <= valid_r;
                end
                OFF_CONTROL: begin
                    PRDATA[CT_RUN]     <= run_r;
                    PRDATA[CT_REQUEST] <= req_r;
                end
                // Narrow registers sit in the low bits; the rest reads zero.
                OFF_CODE:     PRDATA[15:0]       <= code_r;
                OFF_COUNT:    PRDATA             <= count_r;
                OFF_ERRCODE:  PRDATA[15:0]       <= errcode_r;
                OFF_QUANTITY: PRDATA             <= quantity_r;
                OFF_CONFIG:   PRDATA[1:0]        <= config_r;
                OFF_IRQ_STAT: PRDATA[IRQ_W-1:0]  <= irq_stat_r;
                OFF_IRQ_EN:   PRDATA[IRQ_W-1:0]  <= irq_en_r;
                default:      PRDATA             <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verification/data_logger_store_control_props.sv
`default_nettype none
module data_logger_store_control_props
    import logger_pkg::*;
#(
    parameter int DEPTH_W = 14
) (
    // Clock, reset and bus.
    input wire logic               CLK,
    input wire logic               SYS_RST,
    input wire logic               PSEL,
    input wire logic               PENABLE,
    input wire logic               PWRITE,
    input wire logic [7:0]         PADDR,
    input wire logic [31:0]        PWDATA,
    input wire logic [31:0]        PRDATA,
    input wire logic               PREADY,
    input wire logic               PSLVERR,
    // Card side and interrupt.
    input wire logic               CARD_PRESENT,
    input wire logic               CARD_START,
    input wire logic [DEPTH_W-1:0] CARD_LENGTH,
    input wire logic               IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // High in the access phase of a transfer.
    wire logic acc = PSEL && PENABLE;
    // Status read seen in its access phase.
    wire logic rd_st = acc && !PWRITE && PADDR == OFF_STATUS;
    rdy_high_a: assert property (PREADY && !PSLVERR)
        else $error("bus answer not ready or in error");
    // Read data is loaded at the setup edge and must still stand after the access.
    rdata_hold_a: assert property (acc |=> $stable(PRDATA))
        else $error("read data moved in access phase");
    unmap_zero_a: assert property (acc && !PWRITE && PADDR > OFF_IRQ_CLR |-> PRDATA == 0)
        else $error("unmapped read not zero");
    start_gap_a: assert property (CARD_START |=> !CARD_START [*4])
        else $error("store start repeated while busy");
    len_hold_a: assert property ($changed(CARD_LENGTH) |-> CARD_START)
        else $error("length moved without a start");
    present_read_a: assert property ($stable(CARD_PRESENT) [*6] ##0 rd_st
        |-> PRDATA[ST_PRESENT] == CARD_PRESENT)
        else $error("present bit wrong");
    busy_read_a: assert property (CARD_START ##[2:6] rd_st |-> PRDATA[ST_BUSY])
        else $error("busy bit off during store");
    irq_fall_a: assert property ($fell(IRQ) |-> $past(acc && PWRITE, 2))
        else $error("interrupt dropped without a write");
    cover property (CARD_START);
    cover property ($rose(IRQ));
    cover property (acc && PWRITE && PADDR == OFF_CODE && PWDATA[15:0] == STORE_CODE);
endmodule
bind data_logger_store_control data_logger_store_control_props #(.DEPTH_W(DEPTH_W)) u_props (
    .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CARD_PRESENT(CARD_PRESENT), .CARD_START(CARD_START), .CARD_LENGTH(CARD_LENGTH), .IRQ(IRQ));
`default_nettype wire

// ===== verification/card_model.sv
`default_nettype none
module card_model
    import logger_pkg::*;
(
    input wire logic        CLK,
    input wire logic        start,
    input wire logic        inserted,
    input wire logic        fail_mode,
    input wire logic [15:0] fail_code,
    output var card_resp_s  resp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh = 8'h00; // Start history; the answer window is taps 5 to 7.
    initial resp = '0;
    // Answers each store seven cycles after the start with done or fail held three cycles.
    always @(posedge CLK) begin
        sh <= {sh[6:0], start};
        resp.present <= inserted;
        resp.done <= !fail_mode && |sh[7:5];
        resp.fail <= fail_mode && |sh[7:5];
        // The code is only meaningful with fail, so it toggles otherwise.
        resp.err_code <= (fail_mode && |sh[7:5]) ? fail_code : ~resp.err_code;
    end
endmodule
`default_nettype wire

// ===== verification/data_logger_store_control_tb_top.sv
`default_nettype none
module data_logger_store_control_tb_top
    import logger_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sv = 0, pl = 0, ins = 1, fm = 0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0000_0000, sd = 32'h0000_0000, q;
    logic [3:0]  len, len_at;
    logic [31:0] prd;
    logic        prdy, perr, start, irq;
    card_resp_s  cr;
    int n_mismatch = 0, tests_run = 0, n_start = 0;
    data_logger_store_control #(.DEPTH_W(4)) u_data_logger_store_control (
        .CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .SAMPLE_VALID(sv),
        .SAMPLE_DATA(sd), .PARAMS_LOADED(pl), .CARD_PRESENT(cr.present), .CARD_DONE(cr.done),
        .CARD_FAIL(cr.fail), .CARD_ERR_CODE(cr.err_code), .CARD_START(start),
        .CARD_LENGTH(len), .IRQ(irq));
    card_model u_card_model (.CLK(clk), .start(start), .inserted(ins), .fail_mode(fm),
        .fail_code(16'h00E7), .resp(cr));
    initial forever #12.5 clk = ~clk;
    // Counts store starts and keeps the length given with each.
    always @(posedge clk) if (start === 1'b1) begin
        n_start <= n_start + 1;
        len_at <= len;
    end
    // One APB transfer; read data lands in q.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        q = prd;
        psel <= 0; pen <= 0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e); apb(0, a, 0); chk(q, e); endtask
    task automatic bit_is(input logic [7:0] a, input int b, input logic e);
        apb(0, a, 0);
        chk(32'(q[b]), 32'(e));
    endtask
    task automatic samp(input int n);
        repeat (n) begin
            @(posedge clk); sv <= 1; sd <= sd + 32'h0000_0011;
            @(posedge clk); sv <= 0;
        end
    endtask
    // Polls the busy bit until the store has ended.
    task automatic wait_idle;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 40; i++) begin
            apb(0, OFF_STATUS, 0);
            if (q[ST_BUSY] === 1'b0) break;
        end
        chk(32'(q[ST_BUSY]), 32'h0000_0000);
    endtask
    task automatic t_reset;
        rd(OFF_CONTROL, 0); rd(OFF_COUNT, 0);
        rd(OFF_QUANTITY, QUANTITY_RST); rd(8'h28, 0);
        bit_is(OFF_STATUS, ST_PRESENT, 1);
    endtask
    task automatic t_params;
        wr(OFF_CONTROL, 1); samp(3); rd(OFF_COUNT, 0);
        bit_is(OFF_STATUS, ST_VALID, 0);
        @(posedge clk) pl <= 1;
        repeat (4) @(posedge clk);
        bit_is(OFF_STATUS, ST_VALID, 1);
    endtask
    // Stop-at-quantity with automatic store at the limit.
    task automatic t_limit;
        wr(OFF_QUANTITY, 4); wr(OFF_CONFIG, 2); wr(OFF_CODE, 32'(STORE_CODE)); samp(6);
        rd(OFF_COUNT, 4);
        bit_is(OFF_STATUS, ST_LIMIT, 1);
        chk(32'(n_start), 1); chk(32'(len_at), 4);
        rd(OFF_CONTROL, 1);
        wr(OFF_COUNT, 9); rd(OFF_COUNT, 4);
        wait_idle;
    endtask
    task automatic t_store;
        wr(OFF_CODE, 32'h0000_1234); wr(OFF_CONTROL, 3); wr(OFF_CODE, 32'(STORE_CODE));
        chk(32'(n_start), 1);
        wr(OFF_CONTROL, 1); wr(OFF_CONTROL, 3); rd(OFF_CONTROL, 3);
        bit_is(OFF_STATUS, ST_BUSY, 1);
        chk(32'(n_start), 2);
        wr(OFF_CONTROL, 3); wait_idle; chk(32'(n_start), 2);
        bit_is(OFF_IRQ_STAT, IRQ_DONE, 1);
    endtask
    // Failing store, then interrupt raise, mask and clear.
    task automatic t_fail;
        @(posedge clk) fm <= 1;
        // The program enables the error interrupt, then leaves it alone until the store is over.
        wr(OFF_IRQ_EN, 4); wr(OFF_CONTROL, 1); wr(OFF_CONTROL, 3); wait_idle;
        bit_is(OFF_STATUS, ST_ERROR, 1);
        rd(OFF_ERRCODE, 32'h0000_00E7);
        chk(32'(irq), 1);
        wr(OFF_IRQ_EN, 0); repeat (2) @(posedge clk); chk(32'(irq), 0);
        wr(OFF_IRQ_EN, 4); wr(OFF_IRQ_CLR, 4); repeat (2) @(posedge clk); chk(32'(irq), 0);
        bit_is(OFF_IRQ_STAT, IRQ_ERROR, 0);
    endtask
    task automatic t_wrap;
        wr(OFF_CONFIG, 1); samp(20); rd(OFF_COUNT, 24);
        bit_is(OFF_STATUS, ST_LIMIT, 1);
        wr(OFF_CONTROL, 0); samp(2); rd(OFF_COUNT, 24);
    endtask
    task automatic t_remove;
        @(posedge clk) ins <= 0;
        repeat (6) @(posedge clk);
        bit_is(OFF_STATUS, ST_PRESENT, 0);
        wr(OFF_CONTROL, 2); rd(OFF_CONTROL, 2); chk(32'(n_start), 3);
    endtask
    task automatic print_verdict;
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        t_reset; t_params; t_limit; t_store; t_fail; t_wrap; t_remove;
        print_verdict;
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict;
    end
endmodule
`default_nettype wire
